// ### aus_pkg.sv
// Constants for the error reporting capability header and uncorrectable status bank.
// Assumes a 32-bit AHB-Lite register bus and word-aligned register offsets.
package aus_pkg;

    // ========================================================
    // Register map
    localparam logic [11:0] AUS_OFS_CAP_HEADER = 12'h100;
    localparam logic [11:0] AUS_OFS_UNC_STATUS = 12'h104;
    localparam int AUS_ADDR_LSB = 2;
    localparam int AUS_ADDR_MSB = 11;

    // ========================================================
    // Capability header fields
    localparam logic [15:0] AUS_CAP_ID = 16'h0001;
    localparam logic [3:0] AUS_CAP_VER = 4'h2;
    localparam int AUS_CAP_ID_LSB = 0;
    localparam int AUS_CAP_VER_LSB = 16;
    localparam int AUS_NXT_PTR_LSB = 20;
    localparam int AUS_NXT_PTR_W = 12;
    localparam logic [11:0] AUS_NXT_PTR_RESET = 12'h000;

    // ========================================================
    // Status bit positions
    localparam int AUS_BIT_LEGACY = 0;
    localparam int AUS_BIT_LINK_PROTO = 4;
    localparam int AUS_BIT_SURPRISE_DOWN = 5;
    localparam int AUS_BIT_POISONED = 12;
    localparam int AUS_BIT_FLOW_CTRL = 13;
    localparam int AUS_BIT_CPL_TIMEOUT = 14;
    localparam int AUS_BIT_CPL_ABORT = 15;
    localparam int AUS_BIT_UNEXP_CPL = 16;
    localparam int AUS_BIT_RX_OVERFLOW = 17;
    localparam int AUS_BIT_MALFORMED = 18;
    localparam int AUS_BIT_ECRC = 19;
    localparam int AUS_BIT_UNSUPP_REQ = 20;
    localparam int AUS_BIT_ACS_VIOL = 21;
    localparam int AUS_BIT_INTERNAL = 22;
    localparam int AUS_BIT_MCAST_BLK = 23;
    localparam int AUS_BIT_ATOMIC_BLK = 24;
    localparam int AUS_BIT_PREFIX_BLK = 25;

    // Bits that hold sticky write-one-to-clear state; all others read zero
    localparam logic [31:0] AUS_STICKY_MASK = 32'h007F_5011;
    localparam logic [31:0] AUS_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] AUS_ZERO_WORD = 32'h0000_0000;

    // ========================================================
    // AHB-Lite encodings
    localparam logic [1:0] AUS_HTRANS_NONSEQ = 2'h2;
    localparam logic AUS_HRESP_OKAY = 1'h0;

endpackage : aus_pkg

// ### aus_bank.sv
// Error reporting capability header and uncorrectable error status registers.
// Assumes a single AHB-Lite master, single word transfers, detectors giving one-cycle pulses
// synchronous to ref_clk, and resetn asserted only on a cold power-on reset.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// R1: Header bits 15:0 read a fixed capability identifier of 1.
// R2: Header bits 19:16 read a fixed capability version of 2.
// R3: Header bits 31:20 hold next pointer, defaulting per current port mode.
// R4: After software writes the pointer, mode changes no longer reload it.
// R5: Bit 4 sets on link protocol error; sticky, resets zero, write one clears.
// R6: Bit 12 sets on poisoned packet; sticky, write one clears.
// R7: Bit 14 sets on completion timeout; sticky, write one clears.
// R8: Bit 16 sets on unexpected completion; sticky, write one clears.
// R9: Bit 17 sets on receiver overflow; sticky, write one clears.
// R10: Bit 18 sets on malformed packet; sticky, write one clears.
// R11: Bit 19 sets on end-to-end CRC failure; sticky, write one clears.
// R12: Bit 20 sets on unsupported request; sticky, write one clears.
// R13: Bit 21 sets on access control violation; sticky, write one clears.
// R14: Bit 22 sets on uncorrectable internal error; sticky, write one clears.
// R15: Bit 22 is read-only zero while internal error reporting is disabled.
// R16: Bit 0 is an unused legacy flag, reset zero, never set.
// R17: Surprise-down bit 5 reads zero, read-only.
// R18: Flow control error bit 13 reads zero, read-only.
// R19: Completer abort bit 15 reads zero, read-only.
// R20: Multicast blocked bit 23 reads zero, read-only.
// R21: Atomic egress bit 24 and prefix blocked bit 25 read zero.
// R22: Reserved bits 3:1, 11:6, 31:26 read zero, writes ignored.
// R23: Sticky bits survive conventional and hot resets; only cold reset clears.
module aus_bank
    import aus_pkg::*;
#(
    parameter int MODE_W = 2,
    parameter logic [(1 << MODE_W) * AUS_NXT_PTR_W - 1:0] NXT_PTR_MODE_DEFAULTS = '0
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic warm_reset,
    input wire logic [MODE_W-1:0] port_mode,
    input wire logic internal_error_report_enable,
    input wire logic link_protocol_error,
    input wire logic poisoned_packet,
    input wire logic completion_timeout,
    input wire logic unexpected_completion,
    input wire logic receiver_overflow,
    input wire logic malformed_packet,
    input wire logic ecrc_error,
    input wire logic unsupported_request,
    input wire logic access_control_violation,
    input wire logic internal_fault,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [31:0] uncorrectable_error_status,
    output logic mode_switch_retained
);

    // ========================================================
    // Decoding shared by the read and write paths
    function automatic logic hit(input logic [31:0] addr, input logic [11:0] ofs);
        hit = (addr[AUS_ADDR_MSB:AUS_ADDR_LSB] == ofs[AUS_ADDR_MSB:AUS_ADDR_LSB]);
    endfunction : hit

    function automatic logic [AUS_NXT_PTR_W-1:0] mode_default(input logic [MODE_W-1:0] m);
        mode_default = NXT_PTR_MODE_DEFAULTS[m * AUS_NXT_PTR_W +: AUS_NXT_PTR_W];
    endfunction : mode_default

    // ========================================================
    // Bus slave: zero wait states, always OKAY
    logic wr_pend;
    logic wr_header;
    logic wr_status;
    logic addr_phase;
    logic rd_now;

    assign addr_phase = hsel && hready && (htrans == AUS_HTRANS_NONSEQ);
    assign rd_now = addr_phase && !hwrite;
    assign hreadyout = 1'b1;
    assign hresp = AUS_HRESP_OKAY;

    // Warm reset drops a pending write but leaves all held state alone
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend <= 1'b0;
            wr_header <= 1'b0;
            wr_status <= 1'b0;
        end else if (warm_reset) begin
            wr_pend <= 1'b0;
            wr_header <= 1'b0;
            wr_status <= 1'b0;
        end else begin
            wr_pend <= addr_phase && hwrite;
            wr_header <= addr_phase && hwrite && hit(haddr, AUS_OFS_CAP_HEADER);
            wr_status <= addr_phase && hwrite && hit(haddr, AUS_OFS_UNC_STATUS);
        end
    end

    // ========================================================
    // Next structure pointer
    logic [AUS_NXT_PTR_W-1:0] ptr_sw;
    logic [AUS_NXT_PTR_W-1:0] next_ptr;
    logic next_retained;

    assign next_retained = mode_switch_retained || (wr_pend && wr_header);

    always_comb begin
        if (wr_pend && wr_header) begin
            next_ptr = hwdata[AUS_NXT_PTR_LSB +: AUS_NXT_PTR_W];
        end else if (mode_switch_retained) begin
            next_ptr = ptr_sw; // R4
        end else begin
            next_ptr = mode_default(port_mode); // R3
        end
    end

    // Retention is cold-reset only, so a warm reset keeps the software value
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_switch_retained <= 1'b0;
            ptr_sw <= AUS_NXT_PTR_RESET;
        end else begin
            mode_switch_retained <= next_retained; // R4
            ptr_sw <= next_ptr;
        end
    end

    // ========================================================
    // Sticky status bits
    logic [31:0] events;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] writable;
    logic [31:0] next_status;
    logic [31:0] status_q;
    logic [31:0] status_view;

    always_comb begin
        events = AUS_ZERO_WORD;
        events[AUS_BIT_LEGACY] = 1'b0; // R16
        events[AUS_BIT_LINK_PROTO] = link_protocol_error; // R5
        events[AUS_BIT_POISONED] = poisoned_packet; // R6
        events[AUS_BIT_CPL_TIMEOUT] = completion_timeout; // R7
        events[AUS_BIT_UNEXP_CPL] = unexpected_completion; // R8
        events[AUS_BIT_RX_OVERFLOW] = receiver_overflow; // R9
        events[AUS_BIT_MALFORMED] = malformed_packet; // R10
        events[AUS_BIT_ECRC] = ecrc_error; // R11
        events[AUS_BIT_UNSUPP_REQ] = unsupported_request; // R12
        events[AUS_BIT_ACS_VIOL] = access_control_violation; // R13
        events[AUS_BIT_INTERNAL] = internal_fault && internal_error_report_enable; // R14 R15
    end

    always_comb begin
        writable = AUS_STICKY_MASK; // R17 R18 R19 R20 R21 R22
        writable[AUS_BIT_INTERNAL] = internal_error_report_enable; // R15
    end

    assign set_vec = events & AUS_STICKY_MASK;
    assign clr_vec = (wr_pend && wr_status) ? (hwdata & writable) : AUS_ZERO_WORD;
    // Set wins over a clear in the same cycle so no event is lost
    assign next_status = (status_q & ~clr_vec) | set_vec;

    // Only a cold reset clears these; warm_reset is deliberately absent
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_status
            if (AUS_STICKY_MASK[gi]) begin : g_sticky
                always_ff @(posedge ref_clk or negedge resetn) begin
                    if (!resetn) begin
                        status_q[gi] <= AUS_STATUS_RESET[gi]; // R23
                    end else begin
                        status_q[gi] <= next_status[gi]; // R5 R23
                    end
                end
            end else begin : g_zero
                assign status_q[gi] = AUS_STATUS_RESET[gi]; // R17 R18 R19 R20 R21 R22
            end
        end
    endgenerate

    always_comb begin
        status_view = status_q;
        if (!internal_error_report_enable) begin
            status_view[AUS_BIT_INTERNAL] = 1'b0; // R15
        end
    end

    assign uncorrectable_error_status = status_view;

    // ========================================================
    // Read data, taken at the address phase from next values so a write
    // directly ahead is already visible
    logic [31:0] header_word;
    logic [31:0] status_rd;

    always_comb begin
        header_word = AUS_ZERO_WORD;
        header_word[AUS_CAP_ID_LSB +: 16] = AUS_CAP_ID; // R1
        header_word[AUS_CAP_VER_LSB +: 4] = AUS_CAP_VER; // R2
        header_word[AUS_NXT_PTR_LSB +: AUS_NXT_PTR_W] = next_ptr; // R3
        status_rd = next_status;
        if (!internal_error_report_enable) begin
            status_rd[AUS_BIT_INTERNAL] = 1'b0; // R15
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= AUS_ZERO_WORD;
        end else if (rd_now) begin
            if (hit(haddr, AUS_OFS_CAP_HEADER)) begin
                hrdata <= header_word;
            end else if (hit(haddr, AUS_OFS_UNC_STATUS)) begin
                hrdata <= status_rd;
            end else begin
                hrdata <= AUS_ZERO_WORD;
            end
        end
    end

endmodule : aus_bank

// ### aus_bank_properties.sv
// Concurrent checks on the ports of the capability header and uncorrectable status bank.
// Assumes one AHB-Lite master and that hready follows hreadyout.
`timescale 1ns/10ps
module aus_bank_properties
    import aus_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic warm_reset,
    input wire logic internal_error_report_enable,
    input wire logic link_protocol_error,
    input wire logic poisoned_packet,
    input wire logic internal_fault,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] uncorrectable_error_status,
    input wire logic mode_switch_retained
);
    // ========================================================
    // Write data phase trackers
    wire logic [31:0] st = uncorrectable_error_status;
    wire logic ien = internal_error_report_enable;
    wire logic take = hsel && hready && htrans == AUS_HTRANS_NONSEQ && hwrite;
    logic wr_st;
    logic wr_hd;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_st <= 1'b0;
            wr_hd <= 1'b0;
        end else begin
            // A warm reset on the address edge drops that write
            wr_st <= take && !warm_reset && haddr[11:2] == AUS_OFS_UNC_STATUS[11:2];
            wr_hd <= take && !warm_reset && haddr[11:2] == AUS_OFS_CAP_HEADER[11:2];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ========================================================
    // Properties
    property p_unused_zero;
        (st & 32'hFF80_AFEF) == 32'h0000_0000;
    endproperty
    property p_link_set;
        link_protocol_error |=> st[4];
    endproperty
    property p_poison_set;
        poisoned_packet |=> st[12];
    endproperty
    property p_internal_set;
        internal_fault && ien ##1 ien |-> st[22];
    endproperty
    property p_internal_hidden;
        !ien |-> !st[22];
    endproperty
    property p_w1c;
        wr_st && hwdata[12] && !poisoned_packet |=> !st[12];
    endproperty
    // Bit 22 excluded: dropping the enable also hides it
    property p_clear_by_write;
        (($past(st) & ~st & 32'h003F_5010) != 0) |->
            $past(wr_st) && (($past(st) & ~st & ~$past(hwdata) & 32'h003F_5010) == 0);
    endproperty
    property p_retain_rise;
        $rose(mode_switch_retained) |-> $past(wr_hd);
    endproperty
    property p_retain_hold;
        mode_switch_retained |=> mode_switch_retained;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused status bit set");
    a_link_set: assert property (p_link_set) else $error("bit 4 not set");
    a_poison_set: assert property (p_poison_set) else $error("bit 12 not set");
    a_internal_set: assert property (p_internal_set) else $error("bit 22 not set");
    a_internal_hidden: assert property (p_internal_hidden) else $error("bit 22 visible");
    a_w1c: assert property (p_w1c) else $error("bit 12 not cleared");
    a_clear_by_write: assert property (p_clear_by_write) else $error("bit lost");
    a_retain_rise: assert property (p_retain_rise) else $error("retained without write");
    a_retain_hold: assert property (p_retain_hold) else $error("retained dropped");
    c_poison: cover property (poisoned_packet ##1 st[12]);
    c_retain: cover property ($rose(mode_switch_retained));
    c_w1c: cover property (wr_st && hwdata[12] && st[12]);
endmodule : aus_bank_properties

bind aus_bank aus_bank_properties u_props (.ref_clk(ref_clk), .resetn(resetn),
    .warm_reset(warm_reset), .internal_error_report_enable(internal_error_report_enable),
    .link_protocol_error(link_protocol_error), .poisoned_packet(poisoned_packet),
    .internal_fault(internal_fault), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .uncorrectable_error_status(uncorrectable_error_status),
    .mode_switch_retained(mode_switch_retained));

// ### tb_aus_bank.sv
// Self-checking bench for the capability header and uncorrectable status bank.
// Assumes the bank's hreadyout is fed back as the bus hready.
`timescale 1ns/10ps
module tb_aus_bank
    import aus_pkg::*;
;
    localparam logic [47:0] DEFS = 48'h3C0_2B0_1A0_000;
    logic ref_clk = 1'b0, resetn = 1'b0, warm_reset = 1'b0, en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] port_mode = 2'h0, htrans = 2'h0;
    logic [9:0] ev = 10'h000;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, exp_st, d;
    wire logic hreadyout, hresp, retained;
    wire logic [31:0] hrdata, ues;
    int miscompares = 0, comparisons = 0, seed = 94, i;
    aus_bank #(.MODE_W(2), .NXT_PTR_MODE_DEFAULTS(DEFS)) dut_u (.ref_clk(ref_clk),
        .resetn(resetn), .warm_reset(warm_reset), .port_mode(port_mode),
        .internal_error_report_enable(en), .link_protocol_error(ev[0]), .poisoned_packet(ev[1]),
        .completion_timeout(ev[2]), .unexpected_completion(ev[3]), .receiver_overflow(ev[4]),
        .malformed_packet(ev[5]), .ecrc_error(ev[6]), .unsupported_request(ev[7]),
        .access_control_violation(ev[8]), .internal_fault(ev[9]), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .uncorrectable_error_status(ues),
        .mode_switch_retained(retained));
    // ========================================================
    // Expectation helpers and bus tasks
    function automatic logic [31:0] ev_bits(input logic [9:0] v, input logic e);
        ev_bits = {9'h0, v[9] & e, v[8:5], v[4:3], 1'b0, v[2], 1'b0, v[1], 7'h0, v[0], 4'h0};
    endfunction : ev_bits
    // Bit 22 is hidden, not lost, while the enable is low
    function automatic logic [31:0] vis();
        vis = en ? exp_st : exp_st & 32'hFFBF_FFFF;
    endfunction : vis
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dat);
        @(posedge ref_clk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, dat};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        if (w && a == 32'h104) exp_st &= ~(dat & (en ? 32'h007F_5010 : 32'h003F_5010));
    endtask : bus
    task automatic pulse(input logic [9:0] v);
        @(posedge ref_clk);
        ev <= v;
        @(posedge ref_clk);
        ev <= 10'h000;
        exp_st |= ev_bits(v, en);
    endtask : pulse
    task automatic rd_status();
        bus(1'b0, 32'h104, 32'h0);
        check("status", q, vis());
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask : rd_status
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // ========================================================
    // Clock, timeout and main sequence
    initial forever #20 ref_clk = ~ref_clk;
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        exp_st = 32'h0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_status();
        check("retained", {31'h0, retained}, 32'h0);
        for (i = 0; i < 4; i++) begin
            port_mode <= i[1:0];
            bus(1'b0, 32'h100, 32'h0);
            check("header", q, {DEFS[i*12 +: 12], 20'h20001});
        end
        for (i = 0; i < 10; i++) begin
            pulse(10'h001 << i);
            rd_status();
        end
        check("status port", ues, vis());
        warm_reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        warm_reset <= 1'b0;
        rd_status();
        bus(1'b1, 32'h104, 32'hFFFF_FFFF);
        rd_status();
        pulse(10'h200);
        en <= 1'b0;
        rd_status();
        bus(1'b1, 32'h104, 32'h0040_0000);
        pulse(10'h200);
        en <= 1'b1;
        rd_status();
        d = $random(seed);
        bus(1'b1, 32'h100, d);
        port_mode <= ~port_mode;
        bus(1'b0, 32'h100, 32'h0);
        check("header kept", q, {d[31:20], 20'h20001});
        check("retained", {31'h0, retained}, 32'h1);
        bus(1'b1, 32'h108, 32'($random(seed)));
        bus(1'b0, 32'h108, 32'h0);
        check("unmapped", q, 32'h0);
        for (i = 0; i < 30; i++) begin
            pulse(10'($random(seed)));
            bus(1'b1, 32'h104, 32'($random(seed)));
            rd_status();
        end
        // Set beats a clear that lands on the same edge
        fork
            bus(1'b1, 32'h104, 32'h0000_1000);
            begin
                repeat (2) @(posedge ref_clk);
                ev <= 10'h002;
                @(posedge ref_clk);
                ev <= 10'h000;
            end
        join
        exp_st |= 32'h0000_1000;
        rd_status();
        end_of_test();
    end
endmodule : tb_aus_bank
